// ---- rtl/capture_sync_trigger_select.sv ----
// capture channel source select, trigger status and capture timer gating
// assumes event inputs are one-cycle pulses synchronous to core_clk
//
// Overview of operation
// - status reads 1 while timer triggered and running
// - in trigger mode a source event sets status; software reads/sets/clears
// - bit five reads zero, writes ignored
// - codes 00000 and 11111 mean no source
// - 11100 charge-time, 11011 converter, 11010-11000 comparators
// - 10000-10011 select capture channels one to four
// - 01011-01111 timers one-five; 01101 is reset default
// - 00001-00100 select compare channels one to four
// - 01010 selects this channel's pattern trigger output
// - trigger mode starts timer; else synchronizes it
// - cascade set on both channels of the pair: pair forms one 32-bit capture
`timescale 1ns/10ps
module capture_sync_trigger_select
  import capture_sync_pkg::*;
#(
  parameter int TIMER_WIDTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // neighbouring module events
  input wire source_events_t srcEvents,
  // partner channel of the odd/even pair
  input wire logic partnerCascadeSel,
  input wire logic partnerCarry,
  // block outputs
  output logic timerRunning,
  output logic sourceEvent,
  output logic [TIMER_WIDTH-1:0] captureTimer,
  output logic carryOut,
  output logic cascadeActive
);

  // selected source event for a given code; unlisted codes give nothing
  // the index is cut to the width of each event group, the range test keeps it in bounds
  function automatic logic pick_source(input logic [4:0] code, input source_events_t ev);
    logic hit;
    hit = 1'b0;
    if (code >= SRC_COMPARE_FIRST && code <= SRC_COMPARE_LAST) begin
      hit = ev.compareEvt[2'(code - SRC_COMPARE_FIRST)];
    end else if (code == SRC_PATTERN) begin
      hit = ev.patternEvt;
    end else if (code >= SRC_TIMER_FIRST && code <= SRC_TIMER_LAST) begin
      hit = ev.timerEvt[3'(code - SRC_TIMER_FIRST)];
    end else if (code >= SRC_CAPTURE_FIRST && code <= SRC_CAPTURE_LAST) begin
      hit = ev.captureEvt[2'(code - SRC_CAPTURE_FIRST)]; // own index is software's job
    end else if (code >= SRC_COMP_ONE && code <= SRC_COMP_THREE) begin
      hit = ev.comparatorEvt[2'(code - SRC_COMP_ONE)];
    end else if (code == SRC_CONVERTER) begin
      hit = ev.converterEvt;
    end else if (code == SRC_CHARGE_TIME) begin
      hit = ev.chargeTimeEvt; // used in trigger mode by software
    end
    return hit; // 00000, 11111 and reserved stay quiet
  endfunction

  // register state
  ctrl_fields_t ctrl_reg, ctrl_next;
  logic trigger_status_reg, trigger_status_next;
  logic [TIMER_WIDTH-1:0] timer_reg, timer_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic [31:0] rdata_reg, rdata_next;
  logic evt_reg, evt_next;
  logic carry_reg, carry_next;
  logic casc_reg, casc_next;

  logic busReq;
  logic wrCtrl;
  logic wrTimer;
  logic evtNow;
  logic cascOn;
  logic [15:0] ctrlView;

  // a standing ack or err blocks a second take of the same held request
  assign busReq = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
  assign wrCtrl = busReq && wb_we_i && wb_adr_i == CTRL_TWO_OFFSET;
  assign wrTimer = busReq && wb_we_i && wb_adr_i == TIMER_OFFSET;
  assign evtNow = pick_source(ctrl_reg.sourceSel, srcEvents);
  assign cascOn = ctrl_reg.cascadeSel && partnerCascadeSel;

  // register view, bit five and upper bits always zero
  always_comb begin
    ctrlView = 16'h0000;
    ctrlView[CASCADE_BIT] = ctrl_reg.cascadeSel;
    ctrlView[TRIG_MODE_BIT] = ctrl_reg.trigModeSel;
    ctrlView[TRIG_STAT_BIT] = trigger_status_reg;
    ctrlView[GAP_BIT] = 1'b0;
    ctrlView[SRC_LSB +: 5] = ctrl_reg.sourceSel;
  end

  // bus slave: one-cycle answer, err on unmapped address
  always_comb begin
    ack_next = 1'b0;
    err_next = 1'b0;
    rdata_next = 32'h0000_0000;
    if (busReq) begin
      if (wb_adr_i == CTRL_TWO_OFFSET) begin
        ack_next = 1'b1;
        rdata_next = {16'h0000, ctrlView};
      end else if (wb_adr_i == TIMER_OFFSET) begin
        ack_next = 1'b1;
        rdata_next = {16'h0000, 16'(timer_reg)};
      end else begin
        err_next = 1'b1;
      end
    end
  end

  // control fields, byte lanes honoured, bit five has no storage
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wrCtrl && wb_sel_i[1]) begin
      ctrl_next.cascadeSel = wb_dat_i[CASCADE_BIT];
    end
    if (wrCtrl && wb_sel_i[0]) begin
      ctrl_next.trigModeSel = wb_dat_i[TRIG_MODE_BIT];
      ctrl_next.sourceSel = wb_dat_i[SRC_LSB +: 5];
    end
  end

  // trigger status: a source event in trigger mode wins over a software clear
  always_comb begin
    trigger_status_next = trigger_status_reg;
    if (wrCtrl && wb_sel_i[0]) begin
      trigger_status_next = wb_dat_i[TRIG_STAT_BIT];
    end
    if (evtNow && ctrl_reg.trigModeSel) begin
      trigger_status_next = 1'b1;
    end
  end

  // capture timer; in cascade the upper half counts on partner carry
  // a timer write wins over everything so software can preload even a running timer
  always_comb begin
    timer_next = timer_reg;
    carry_next = 1'b0;
    if (ctrl_reg.trigModeSel && !trigger_status_reg) begin
      timer_next = '0; // held clear until triggered
    end else if (!ctrl_reg.trigModeSel && evtNow) begin
      timer_next = '0; // sync restarts, keeps counting after
    end else if (!cascOn || partnerCarry) begin
      timer_next = timer_reg + TIMER_WIDTH'(1);
      carry_next = &timer_reg;
    end
    if (wrTimer) begin
      timer_next = TIMER_WIDTH'(wb_dat_i[15:0]);
    end
    evt_next = evtNow;
    casc_next = cascOn;
  end

  // all state registers
  // reset loads constants only, so the async branch never depends on live logic
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= '{cascadeSel: 1'b0, trigModeSel: 1'b0, sourceSel: SRC_RESET};
      trigger_status_reg <= 1'b0;
      timer_reg <= TIMER_WIDTH'(TIMER_RESET);
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      evt_reg <= 1'b0;
      carry_reg <= 1'b0;
      casc_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      trigger_status_reg <= trigger_status_next;
      timer_reg <= timer_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      rdata_reg <= rdata_next;
      evt_reg <= evt_next;
      carry_reg <= carry_next;
      casc_reg <= casc_next;
    end
  end

  // every output comes straight from a register
  assign wb_dat_o = rdata_reg;
  assign wb_ack_o = ack_reg;
  assign wb_err_o = err_reg;
  assign timerRunning = trigger_status_reg;
  assign sourceEvent = evt_reg;
  assign captureTimer = timer_reg;
  assign carryOut = carry_reg;
  assign cascadeActive = casc_reg;

  // checks: trigger status, timer steps, source mapping and the cascade pair
  sequence trig_evt_s;
    ctrl_reg.trigModeSel && evtNow;
  endsequence

  // a sync event restarts the timer whatever it held before
  sequence sync_evt_s;
    !ctrl_reg.trigModeSel && evtNow && !wrTimer;
  endsequence

  // after a restart the timer shows zero and then one
  sequence sync_restart_s;
    timer_reg == '0 ##1 timer_reg == TIMER_WIDTH'(1);
  endsequence

  // a plain count step: no write, no hold, no restart, a carry while cascaded
  sequence count_step_s;
    !wrTimer && !evtNow && !(ctrl_reg.trigModeSel && !trigger_status_reg) && (!cascOn || partnerCarry);
  endsequence

  // status may move only for a source event or a write of its byte lane
  sequence status_quiet_s;
    !evtNow && !(wrCtrl && wb_sel_i[0]);
  endsequence

  // a cascaded upper half with no carry from its partner
  sequence cascade_wait_s;
    cascOn && !partnerCarry && !wrTimer && !evtNow && !(ctrl_reg.trigModeSel && !trigger_status_reg);
  endsequence

  AST_TRIG_SETS: assert property (@(posedge core_clk) disable iff (!reset_n)
    trig_evt_s |=> trigger_status_reg) else $error("trigger event did not set status");
  AST_HELD_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.trigModeSel && !trigger_status_reg && !wrTimer) |=> timer_reg == '0)
    else $error("timer not held clear before trigger");
  AST_BIT5_ZERO: assert property (@(posedge core_clk) disable iff (!reset_n)
    (busReq && !wb_we_i && wb_adr_i == CTRL_TWO_OFFSET) |=> !wb_dat_o[GAP_BIT])
    else $error("bit five read as one");
  AST_NONE_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel == SRC_NONE_LO || ctrl_reg.sourceSel == SRC_NONE_HI) |-> !evtNow)
    else $error("no-source code produced event");
  AST_RESERVED_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel inside {5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h14, 5'h15, 5'h16, 5'h17, 5'h1d, 5'h1e})
    |-> !evtNow) else $error("reserved code produced event");
  AST_TIMER3_MAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel == 5'h0d) |-> evtNow == srcEvents.timerEvt[2]) else $error("timer three mapping wrong");
  AST_CHARGE_TIME_UNIT_MAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel == 5'h1c) |-> evtNow == srcEvents.chargeTimeEvt) else $error("charge-time mapping wrong");
  AST_SYNC_ZERO: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sync_evt_s ##1 count_step_s) |-> sync_restart_s)
    else $error("sync did not restart timer");
  AST_CASCADE_PAIR: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(ctrl_reg.cascadeSel && partnerCascadeSel) |=> !cascadeActive) else $error("cascade with one side only");
  AST_IC_MAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel == 5'h11) |-> evtNow == srcEvents.captureEvt[1]) else $error("capture two mapping wrong");
  AST_OC_MAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel == 5'h04) |-> evtNow == srcEvents.compareEvt[3]) else $error("compare four mapping wrong");

  // software access to the status flag and what leaves it alone
  AST_SW_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    (wrCtrl && wb_sel_i[0] && wb_dat_i[TRIG_STAT_BIT]) |=> trigger_status_reg)
    else $error("software set of status lost");
  AST_SW_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
    (wrCtrl && wb_sel_i[0] && !wb_dat_i[TRIG_STAT_BIT] && !(evtNow && ctrl_reg.trigModeSel)) |=> !trigger_status_reg)
    else $error("software clear of status lost");
  AST_STATUS_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n)
    status_quiet_s |=> $stable(trigger_status_reg))
    else $error("status moved with no cause");
  AST_SYNC_NO_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!ctrl_reg.trigModeSel && !(wrCtrl && wb_sel_i[0])) |=> $stable(trigger_status_reg))
    else $error("sync mode event changed status");

  // timer steps and the carry out of the top
  AST_RUN_COUNTS: assert property (@(posedge core_clk) disable iff (!reset_n)
    count_step_s |=> timer_reg == $past(timer_reg) + TIMER_WIDTH'(1))
    else $error("timer did not count");
  AST_CARRY_WRAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (count_step_s ##0 (&timer_reg)) |=> carryOut && timer_reg == '0)
    else $error("wrap gave no carry");
  AST_EVT_SEEN: assert property (@(posedge core_clk) disable iff (!reset_n)
    evtNow |=> sourceEvent)
    else $error("selected event not shown");

  // the cascade pair
  AST_CASCADE_ON: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.cascadeSel && partnerCascadeSel) |=> cascadeActive)
    else $error("cascade not active with both sides set");
  AST_CASCADE_WAIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    cascade_wait_s |=> $stable(timer_reg))
    else $error("upper half moved without partner carry");

  // remaining source codes, one at each group end
  AST_CONV_MAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel == SRC_CONVERTER) |-> evtNow == srcEvents.converterEvt)
    else $error("converter mapping wrong");
  AST_COMP_MAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel == SRC_COMP_THREE) |-> evtNow == srcEvents.comparatorEvt[2])
    else $error("comparator three mapping wrong");
  AST_PATTERN_MAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel == SRC_PATTERN) |-> evtNow == srcEvents.patternEvt)
    else $error("pattern trigger mapping wrong");
  AST_TIMER1_MAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel == SRC_TIMER_FIRST) |-> evtNow == srcEvents.timerEvt[0])
    else $error("timer one mapping wrong");
  AST_OC1_MAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_reg.sourceSel == SRC_COMPARE_FIRST) |-> evtNow == srcEvents.compareEvt[0])
    else $error("compare one mapping wrong");

endmodule

// ---- pkg/capture_sync_pkg.sv ----
// package for the capture source select and trigger gating block
// assumes a wishbone classic slave with 32-bit data, registers in low 16 bits
package capture_sync_pkg;

  // register byte offsets
  localparam logic [3:0] CTRL_TWO_OFFSET = 4'h0;
  localparam logic [3:0] TIMER_OFFSET = 4'h4;

  // field positions in capture_control_two
  localparam int CASCADE_BIT = 8;
  localparam int TRIG_MODE_BIT = 7;
  localparam int TRIG_STAT_BIT = 6;
  localparam int GAP_BIT = 5;
  localparam int SRC_LSB = 0;

  // reset values
  localparam logic [4:0] SRC_RESET = 5'h0d;
  localparam logic [15:0] TIMER_RESET = 16'h0000;

  // source select codes
  localparam logic [4:0] SRC_NONE_LO = 5'h00;
  localparam logic [4:0] SRC_COMPARE_FIRST = 5'h01;
  localparam logic [4:0] SRC_COMPARE_LAST = 5'h04;
  localparam logic [4:0] SRC_PATTERN = 5'h0a;
  localparam logic [4:0] SRC_TIMER_FIRST = 5'h0b;
  localparam logic [4:0] SRC_TIMER_LAST = 5'h0f;
  localparam logic [4:0] SRC_CAPTURE_FIRST = 5'h10;
  localparam logic [4:0] SRC_CAPTURE_LAST = 5'h13;
  localparam logic [4:0] SRC_COMP_ONE = 5'h18;
  localparam logic [4:0] SRC_COMP_THREE = 5'h1a;
  localparam logic [4:0] SRC_CONVERTER = 5'h1b;
  localparam logic [4:0] SRC_CHARGE_TIME = 5'h1c;
  localparam logic [4:0] SRC_NONE_HI = 5'h1f;

  // one-cycle event pulses from the neighbouring modules
  typedef struct packed {
    logic [3:0] compareEvt;
    logic [4:0] timerEvt;
    logic [3:0] captureEvt;
    logic [2:0] comparatorEvt;
    logic converterEvt;
    logic chargeTimeEvt;
    logic patternEvt;
  } source_events_t;

  // control fields
  typedef struct packed {
    logic cascadeSel;
    logic trigModeSel;
    logic [4:0] sourceSel;
  } ctrl_fields_t;

endpackage

// ---- tb/capture_partner_model.sv ----
// far-side model: neighbouring event sources and the partner channel of the pair
// assumes bench requests change just after a rising edge of core_clk
`timescale 1ns/10ps
module capture_partner_model
  import capture_sync_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // bench requests
  input wire logic fire,
  input wire source_events_t evReq,
  input wire logic cascadeReq,
  // toward the block
  output source_events_t srcEvents,
  output logic partnerCascadeSel,
  output logic partnerCarry
);
  logic [1:0] carryCnt_reg;

  // events are one-cycle pulses, never held, so no source can retrigger twice
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      srcEvents <= '0;
      partnerCascadeSel <= 1'b0;
      carryCnt_reg <= 2'h0;
    end else begin
      srcEvents <= fire ? evReq : '0;
      partnerCascadeSel <= cascadeReq;
      carryCnt_reg <= carryCnt_reg + 2'h1;
    end
  end

  // lower half wraps every fourth cycle, only while cascaded
  assign partnerCarry = partnerCascadeSel && (carryCnt_reg == 2'h3);
endmodule

// ---- tb/tb_capture_sync_trigger_select.sv ----
// self-checking bench for the capture source select block
// assumes the partner model supplies events and the pair partner
`timescale 1ns/10ps
module tb_capture_sync_trigger_select;
  import capture_sync_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, fire = 1'b0, casReq = 1'b0;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR, seed = 32'h48;
  logic wbAck, wbErr, timerRunning, sourceEvent, carryOut, cascadeActive, partnerCascadeSel, partnerCarry;
  logic [15:0] captureTimer;
  source_events_t srcEvents, evReq = '0;
  logic [33:0] notes[$];
  logic [33:0] head;
  int error_cnt = 0;
  int cmp_count = 0;

  always #12.5 core_clk = ~core_clk;

  capture_sync_trigger_select u_capture_sync_trigger_select (.core_clk(core_clk), .reset_n(reset_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .wb_err_o(wbErr), .srcEvents(srcEvents),
    .partnerCascadeSel(partnerCascadeSel), .partnerCarry(partnerCarry), .timerRunning(timerRunning),
    .sourceEvent(sourceEvent), .captureTimer(captureTimer), .carryOut(carryOut), .cascadeActive(cascadeActive));
  capture_partner_model u_capture_partner_model (.core_clk(core_clk), .reset_n(reset_n), .fire(fire),
    .evReq(evReq), .cascadeReq(casReq), .srcEvents(srcEvents), .partnerCascadeSel(partnerCascadeSel),
    .partnerCarry(partnerCarry));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // expected selected event for a source code
  function automatic logic pick(input logic [4:0] c, input source_events_t e);
    case (c) inside
      [5'h01:5'h04]: pick = e.compareEvt[c - 5'h01];
      5'h0a: pick = e.patternEvt;
      [5'h0b:5'h0f]: pick = e.timerEvt[c - 5'h0b];
      [5'h10:5'h13]: pick = e.captureEvt[c - 5'h10];
      [5'h18:5'h1a]: pick = e.comparatorEvt[c - 5'h18];
      5'h1b: pick = e.converterEvt;
      5'h1c: pick = e.chargeTimeEvt;
      default: pick = 1'b0;
    endcase
  endfunction

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  // note bit 33 asks for a data compare, bit 32 expects an error answer
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [33:0] note);
    int n;
    n = 0;
    notes.push_back(note);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'hf;
    wbDatW <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (!(wbAck === 1'b1 || wbErr === 1'b1) && n < 50);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      end_sim();
    end
    @(posedge core_clk);
  endtask

  // the selected event shows on sourceEvent two edges after the request, for one cycle
  task automatic pulse(input source_events_t e, input logic hit);
    evReq <= e;
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("event", {31'h0, hit}, {31'h0, sourceEvent});
    @(posedge core_clk);
    chk("event end", 32'h0, {31'h0, sourceEvent});
  endtask

  // answer watcher: oldest note against each ack or err
  always @(posedge core_clk) begin
    if (wbAck === 1'b1 || wbErr === 1'b1) begin
      head = notes.pop_front();
      chk("err", {31'h0, head[32]}, {31'h0, wbErr});
      if (head[33]) begin
        chk("rdata", head[31:0], wbDatR);
      end
    end
  end

  // main sequence
  initial begin
    source_events_t e;
    int wraps;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, 4'h0, 32'h0, {2'b10, 32'h0000000d});
    bus(1'b1, 4'h0, 32'hffff, 34'h0);
    bus(1'b0, 4'h0, 32'h0, {2'b10, 32'h000001df});
    bus(1'b0, 4'h8, 32'h0, {2'b01, 32'h0});
    // every code but 10000 in trigger mode against random event sets
    for (int c = 0; c < 32; c++) begin
      if (c == 16) continue; // own channel is never its own source
      bus(1'b1, 4'h0, {24'h0, 3'b100, c[4:0]}, 34'h0);
      seed = xs(seed);
      e = seed[16:0];
      e.captureEvt[0] = 1'b0;
      pulse(e, pick(c[4:0], e));
      bus(1'b0, 4'h0, 32'h0, {2'b10, 24'h0, 1'b1, pick(c[4:0], e), 1'b0, c[4:0]});
    end
    bus(1'b1, 4'h0, 32'h80, 34'h0);
    repeat (4) @(posedge core_clk);
    chk("held", 32'h0, {16'h0, captureTimer});
    bus(1'b1, 4'h0, 32'hc0, 34'h0);
    repeat (4) @(posedge core_clk);
    chk("running", 32'h1, {31'h0, timerRunning});
    chk("counting", 32'h1, {31'h0, captureTimer > 16'h0});
    // sync mode from a timer source only, analog sources stay trigger-only
    bus(1'b1, 4'h0, 32'h0b, 34'h0);
    bus(1'b1, 4'h4, 32'h1000, 34'h0);
    e = '0;
    e.timerEvt[0] = 1'b1;
    pulse(e, 1'b1);
    chk("sync", 32'h1, {31'h0, captureTimer > 16'h0 && captureTimer < 16'h8});
    bus(1'b0, 4'h0, 32'h0, {2'b10, 32'h0000000b});
    // free-running timer preloaded near the top wraps exactly once in the window
    bus(1'b1, 4'h4, 32'hfff0, 34'h0);
    wraps = 0;
    repeat (24) begin
      @(posedge core_clk);
      if (carryOut === 1'b1) begin
        wraps++;
      end
    end
    chk("carry", 32'h1, wraps);
    bus(1'b1, 4'h0, 32'h100, 34'h0);
    repeat (2) @(posedge core_clk);
    chk("cascade", 32'h0, {31'h0, cascadeActive});
    casReq <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("cascade", 32'h1, {31'h0, cascadeActive});
    // upper half counts one per partner carry, every fourth cycle, over 17 edges
    bus(1'b1, 4'h4, 32'h0, 34'h0);
    repeat (16) @(posedge core_clk);
    chk("cascade count", 32'h1, {31'h0, captureTimer >= 16'h4 && captureTimer <= 16'h5});
    end_sim();
  end

  // watchdog: the full run needs well under a thousand cycles
  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end
endmodule
